// ===== shared/spr_pkg.sv
// Purpose: Shared constants and types of the digital audio receiver control block.
// Assumes: 100 MHz system clock; register indices are multiplied by four for byte addresses.
// Notes: The link carries 32-slot subframes, one bit per link clock rising edge.
`default_nettype none
package spr_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_LOCK = 16'hF600;
    localparam logic [15:0] IDX_CTRL = 16'hF601;
    localparam logic [15:0] IDX_DECODE = 16'hF602;
    localparam logic [15:0] IDX_COMP = 16'hF603;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hF610;
    localparam logic [15:0] IDX_IRQ_CLEAR = 16'hF611;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'hF612;
    // Control field positions and reset value.
    localparam int CTRL_QUICK_LOCK = 3;
    localparam int CTRL_LOSS_BEHAV = 2;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // Decode register field positions.
    localparam int DEC_RIGHT_LSB = 6;
    localparam int DEC_LEFT_LSB = 2;
    localparam int DEC_FAMILY = 1;
    localparam int DEC_TYPE = 0;
    // Interrupt bits.
    localparam int IRQ_LOCK_GAINED = 0;
    localparam int IRQ_LOCK_LOST = 1;
    localparam int IRQ_FORMAT = 2;
    // Lock run lengths.
    localparam logic [6:0] RUN_NORMAL = 7'h40;
    localparam logic [6:0] RUN_QUICK = 7'h08;
    // Subframe slot layout.
    localparam int SLOT_RIGHT = 1;
    localparam int SLOT_BLOCK = 2;
    localparam int SLOT_VALID = 28;
    localparam int SLOT_CS = 30;
    localparam logic [4:0] SLOT_LAST = 5'h1F;
    // Channel status bit positions.
    localparam logic [7:0] CS_NONAUDIO = 8'h01;
    localparam logic [7:0] CS_LEN_FIRST = 8'h20;
    localparam logic [7:0] CS_LEN_LAST = 8'h23;
    // Burst sync words of compressed streams and the family code range.
    localparam logic [15:0] BURST_SYNC_A = 16'hF872;
    localparam logic [15:0] BURST_SYNC_B = 16'h4E1F;
    localparam logic [4:0] FAMILY_LO = 5'h0B;
    localparam logic [4:0] FAMILY_HI = 5'h0D;
    // Timing: link silence that ends lock.
    localparam int CLK_NS = 10;
    localparam int LOSS_NS = 2000;
    localparam int LOSS_CYC = (LOSS_NS + CLK_NS - 1) / CLK_NS;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded audio pair handed to the user side.
    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
        logic strobe;
    } spr_audio_t;

    // Whole state of the receiver control block.
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic lclk_prev;
        logic [4:0] slot;
        logic [31:0] sub;
        logic [6:0] run;
        logic locked;
        logic mute;
        logic [15:0] idle;
        logic [7:0] cs_idx;
        logic cs_na;
        logic [3:0] cs_l;
        logic [3:0] cs_r;
        logic [3:0] det_l;
        logic [3:0] det_r;
        logic a_type;
        logic family;
        logic [15:0] comp;
        logic [1:0] pstage;
        logic fclk;
        logic [15:0] half;
        logic [15:0] fcnt;
        spr_audio_t aud;
        logic aw_got;
        logic [15:0] aw_idx;
        logic aw_bad;
        logic w_got;
        logic [15:0] w_data;
        logic w_lane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [3:0] ctrl;
        logic [2:0] ist;
        logic [2:0] ien;
        logic irq;
    } spr_state_t;
endpackage
`default_nettype wire

// ===== core/spr_receiver.sv
// Purpose: Lock, loss-of-lock, word length and format decode of a digital audio receiver.
// Assumes: Link slots 0-3 carry preamble flags, 4-27 audio LSB first, then V, U, C, P.
// Notes: Registers are reached over AXI4-Lite; byte address is four times the index.
//
// How it works
// - Quick-lock clear: lock declared after 64 consecutive valid samples.
// - Quick-lock set: lock declared after eight consecutive valid samples.
// - The loss behaviour bit governs the recovered frame clock output.
// - Behaviour 0: frame clock keeps running from its measured period after loss.
// - Behaviour 1: frame clock stops at once when lock is lost.
// - Length select 00 gives 24 bits, 01 gives 20, 10 gives 16.
// - Length select 11 takes the length from received channel status.
// - Decode register bits 9 to 6 show the right detected length code.
// - Decode register bits 5 to 2 show the left detected length code.
// - Codes 0010,1100,0100,1000,1010 mean 16 to 20 bits in 20-bit container.
// - Codes 0011,1101,0101,1001,1011 mean 20 to 24 bits in 24-bit container.
// - Decode bit 0 reads 0 for linear audio, 1 for compressed.
// - Decode bit 1 gives compression family, meaningful only when compressed.
// - Compressed streams expose their 16-bit compression code in a read-only register.
// - Nonaudio bits are decoded once per block, only while locked, to refresh the format fields.
// - Lock flag reads 1 once locked, 0 while no valid stream.
// - Losing lock mutes the audio output automatically.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module spr_receiver #(
    parameter int ADDR_W = 20
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic link_sync,
    output spr_pkg::spr_audio_t audio,
    output logic frame_clk_out,
    output logic lock_out,
    output logic irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Eighteen bits reach the highest register; one more is needed to flag stray addresses.
    if (ADDR_W < 19 || ADDR_W > 32) begin : g_addr_check
        $error("spr_receiver: ADDR_W must lie between 19 and 32");
    end

    localparam logic [15:0] LOSS_LIMIT = 16'(spr_pkg::LOSS_CYC);

    spr_pkg::spr_state_t q;
    spr_pkg::spr_state_t n;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Received length code to bit count; unknown codes fall back to the full word.
    function automatic logic [4:0] code_len(input logic [3:0] c);
        case (c)
            4'h2: code_len = 5'h10;
            4'hC: code_len = 5'h11;
            4'h4: code_len = 5'h12;
            4'h8: code_len = 5'h13;
            4'hA: code_len = 5'h14;
            4'h3: code_len = 5'h14;
            4'hD: code_len = 5'h15;
            4'h5: code_len = 5'h16;
            4'h9: code_len = 5'h17;
            4'hB: code_len = 5'h18;
            default: code_len = 5'h18;
        endcase
    endfunction

    // Keeps the top bits of a sample that the selected length allows.
    function automatic logic [23:0] trim(input logic [23:0] s, input logic [1:0] sel,
                                         input logic [3:0] det);
        logic [4:0] len;
        len = 5'h18;
        case (sel)
            2'h0: len = 5'h18;
            2'h1: len = 5'h14;
            2'h2: len = 5'h10;
            default: len = code_len(det);
        endcase
        trim = s & (24'hFFFFFF << (5'h18 - len));
    endfunction

    // Register read mux.
    function automatic logic [15:0] reg_read(input spr_pkg::spr_state_t s, input logic [15:0] i);
        case (i)
            spr_pkg::IDX_LOCK: reg_read = {15'h0000, s.locked};
            spr_pkg::IDX_CTRL: reg_read = {12'h000, s.ctrl};
            spr_pkg::IDX_DECODE: reg_read = {6'h00, s.det_r, s.det_l, s.family, s.a_type};
            spr_pkg::IDX_COMP: reg_read = s.comp;
            spr_pkg::IDX_IRQ_STATUS: reg_read = {13'h0000, s.ist};
            spr_pkg::IDX_IRQ_ENABLE: reg_read = {13'h0000, s.ien};
            default: reg_read = 16'h0000;
        endcase
    endfunction

    function automatic logic known_idx(input logic [15:0] i);
        known_idx = (i == spr_pkg::IDX_LOCK) || (i == spr_pkg::IDX_CTRL) ||
                    (i == spr_pkg::IDX_DECODE) || (i == spr_pkg::IDX_COMP) ||
                    (i == spr_pkg::IDX_IRQ_STATUS) || (i == spr_pkg::IDX_IRQ_CLEAR) ||
                    (i == spr_pkg::IDX_IRQ_ENABLE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // Link sampling, subframe assembly, lock, decode, frame clock and register bus.
    always_comb begin
        logic edge_seen;
        logic [31:0] w;
        logic done;
        logic is_right;
        logic good;
        logic [6:0] target;
        logic lose;
        logic [2:0] ev;
        logic [2:0] clr;
        logic [15:0] word16;
        logic [15:0] fmt_old;
        edge_seen = 1'b0;
        w = 32'h00000000;
        done = 1'b0;
        is_right = 1'b0;
        good = 1'b0;
        target = spr_pkg::RUN_NORMAL;
        lose = 1'b0;
        ev = 3'h0;
        clr = 3'h0;
        word16 = 16'h0000;
        fmt_old = {q.det_r, q.det_l, q.family, q.a_type, 6'h00};
        n = q;
        n.aud.strobe = 1'b0;

        // Link pins pass two flops; only the second stage is looked at.
        n.s1 = {link_sync, link_data, link_clk};
        n.s2 = q.s1;
        n.lclk_prev = q.s2[0];
        edge_seen = q.s2[0] && !q.lclk_prev;

        // One slot per link rising edge; sync marks slot zero.
        if (edge_seen) begin
            n.idle = 16'h0000;
            n.slot = q.s2[2] ? 5'h00 : q.slot + 5'h01;
            w = q.sub;
            w[n.slot] = q.s2[1];
            n.sub = w;
            done = (n.slot == spr_pkg::SLOT_LAST);
        end else if (q.idle != 16'hFFFF) begin
            n.idle = q.idle + 16'h0001;
        end

        // A sample is valid with V clear and even parity over slots 4 to 31.
        is_right = w[spr_pkg::SLOT_RIGHT];
        good = !w[spr_pkg::SLOT_VALID] && !(^w[31:4]);
        target = q.ctrl[spr_pkg::CTRL_QUICK_LOCK] ? spr_pkg::RUN_QUICK
                                                  : spr_pkg::RUN_NORMAL;
        if (done) begin
            if (!good) begin
                n.run = 7'h00;
                lose = q.locked;
            end else if (q.run != 7'h7F) begin
                n.run = q.run + 7'h01;
            end
            if (good && !q.locked && (q.run + 7'h01 == target)) begin
                n.locked = 1'b1;
                n.mute = 1'b0;
                ev[spr_pkg::IRQ_LOCK_GAINED] = 1'b1;
            end
        end
        // A silent link also ends lock.
        if (q.locked && q.idle >= LOSS_LIMIT) begin
            lose = 1'b1;
            n.run = 7'h00;
        end
        if (lose) begin
            n.locked = 1'b0;
            n.mute = 1'b1;
            ev[spr_pkg::IRQ_LOCK_LOST] = 1'b1;
        end

        // Audio words leave trimmed to the chosen length, zero while muted.
        if (done && good && n.locked) begin
            if (is_right) begin
                n.aud.right = trim(w[27:4], q.ctrl[1:0], q.det_r);
                n.aud.strobe = 1'b1;
            end else begin
                n.aud.left = trim(w[27:4], q.ctrl[1:0], q.det_l);
            end
        end
        if (n.mute) begin
            n.aud.left = 24'h000000;
            n.aud.right = 24'h000000;
        end

        // Channel status gathering over the block; published once lengths are complete.
        if (done && n.locked) begin
            if (!is_right) begin
                n.cs_idx = w[spr_pkg::SLOT_BLOCK] ? 8'h00
                           : (q.cs_idx == 8'hFF ? q.cs_idx : q.cs_idx + 8'h01);
            end
            if (n.cs_idx == spr_pkg::CS_NONAUDIO && !is_right) begin
                n.cs_na = w[spr_pkg::SLOT_CS];
            end
            if (n.cs_idx >= spr_pkg::CS_LEN_FIRST && n.cs_idx <= spr_pkg::CS_LEN_LAST) begin
                if (is_right) begin
                    n.cs_r[n.cs_idx[1:0]] = w[spr_pkg::SLOT_CS];
                end else begin
                    n.cs_l[n.cs_idx[1:0]] = w[spr_pkg::SLOT_CS];
                end
            end
            if (is_right && n.cs_idx == spr_pkg::CS_LEN_LAST) begin
                n.det_l = n.cs_l;
                n.det_r = n.cs_r;
                n.a_type = n.cs_na;
            end
        end

        // Compressed bursts: two sync words, then the burst info word carries the code.
        word16 = w[27:12];
        if (done && good && n.locked) begin
            case (q.pstage)
                2'h0: n.pstage = (!is_right && word16 == spr_pkg::BURST_SYNC_A) ? 2'h1 : 2'h0;
                2'h1: n.pstage = (is_right && word16 == spr_pkg::BURST_SYNC_B) ? 2'h2 : 2'h0;
                2'h2: begin
                    n.pstage = 2'h0;
                    if (!is_right && n.a_type) begin
                        n.comp = word16;
                        n.family = (word16[4:0] >= spr_pkg::FAMILY_LO) &&
                                   (word16[4:0] <= spr_pkg::FAMILY_HI);
                    end
                end
                default: n.pstage = 2'h0;
            endcase
        end
        if ({n.det_r, n.det_l, n.family, n.a_type, 6'h00} != fmt_old) begin
            ev[spr_pkg::IRQ_FORMAT] = 1'b1;
        end

        // Frame clock: follows the link while locked; on loss the behaviour bit decides.
        n.fcnt = q.fcnt + 16'h0001;
        if (n.locked) begin
            if (done && !is_right) begin
                n.fclk = 1'b1;
                n.fcnt = 16'h0000;
            end else if (done && is_right) begin
                n.fclk = 1'b0;
                n.half = q.fcnt;
            end
        end else if (q.ctrl[spr_pkg::CTRL_LOSS_BEHAV]) begin
            n.fclk = 1'b0;
            n.fcnt = 16'h0000;
        end else if (q.half != 16'h0000 && q.fcnt >= q.half) begin
            n.fclk = !q.fclk;
            n.fcnt = 16'h0000;
        end

        // Write channel: address and data taken in either order, answered after both.
        if (s_axi_awvalid && q.awready) begin
            n.aw_got = 1'b1;
            n.aw_idx = s_axi_awaddr[17:2];
            n.aw_bad = (s_axi_awaddr[ADDR_W-1:18] != '0);
        end
        if (s_axi_wvalid && q.wready) begin
            n.w_got = 1'b1;
            n.w_data = s_axi_wdata[15:0];
            n.w_lane = s_axi_wstrb[0];
        end
        if (q.aw_got && q.w_got) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = (q.aw_bad || !known_idx(q.aw_idx)) ? spr_pkg::RESP_SLVERR
                                                          : spr_pkg::RESP_OKAY;
            if (!q.aw_bad && q.w_lane) begin
                case (q.aw_idx)
                    spr_pkg::IDX_CTRL: n.ctrl = q.w_data[3:0];
                    spr_pkg::IDX_IRQ_CLEAR: clr = q.w_data[2:0];
                    spr_pkg::IDX_IRQ_ENABLE: n.ien = q.w_data[2:0];
                    default: n.ctrl = q.ctrl;
                endcase
            end
        end else if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        n.awready = !n.aw_got && !n.bvalid && !(q.aw_got && q.w_got);
        n.wready = !n.w_got && !n.bvalid && !(q.aw_got && q.w_got);

        // Read channel: one read at a time, answered the cycle after the address.
        if (s_axi_arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rdata = (s_axi_araddr[ADDR_W-1:18] != '0) ? 32'h00000000
                      : {16'h0000, reg_read(q, s_axi_araddr[17:2])};
            n.rresp = ((s_axi_araddr[ADDR_W-1:18] == '0) && known_idx(s_axi_araddr[17:2]))
                      ? spr_pkg::RESP_OKAY : spr_pkg::RESP_SLVERR;
        end else if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        n.arready = !n.rvalid;

        // Sticky status: a new event wins over a clear in the same cycle.
        n.ist = (q.ist & ~clr) | ev;
        n.irq = |(n.ist & n.ien);
    end

    // State register; reset brings every field to zero.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from state flops.

    assign audio = q.aud;
    assign frame_clk_out = q.fclk;
    assign lock_out = q.locked;
    assign irq = q.irq;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence lock_rises;
        $rose(q.locked);
    endsequence

    sequence lock_falls;
        $fell(q.locked);
    endsequence

    normal_run_a: assert property (lock_rises and !q.ctrl[3] |-> q.run == 7'h40)
        else $error("lock taken without 64 valid samples");
    quick_run_a: assert property (lock_rises and q.ctrl[3] |-> q.run == 7'h08)
        else $error("quick lock taken without eight valid samples");
    loss_mutes_a: assert property (lock_falls |-> q.mute ##1 (audio.left == 24'h000000))
        else $error("audio not muted after loss of lock");
    weak_stop_a: assert property (lock_falls and q.ctrl[2] |-> !frame_clk_out)
        else $error("frame clock still running after loss in stop mode");
    strong_run_a: assert property (!q.locked && !q.ctrl[2] && q.half != 16'h0000 &&
                                   q.fcnt >= q.half |=> $changed(frame_clk_out))
        else $error("frame clock stalled after loss in keep mode");
    short_word_a: assert property (audio.strobe && q.ctrl[1:0] == 2'h2 |->
                                   audio.right[7:0] == 8'h00)
        else $error("16-bit selection left low bits set");
    reset_clear_a: assert property ($fell(sys_rst) |-> q.ctrl == 4'h0 && q.det_l == 4'h0 &&
                                    q.comp == 16'h0000)
        else $error("state not cleared by reset");
    lock_flag_a: assert property (lock_out |-> q.run >= 7'h08)
        else $error("lock flag set without a valid run");
    irq_level_a: assert property (irq == |(q.ist & q.ien))
        else $error("interrupt output disagrees with enabled status");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before it was taken");
endmodule
`default_nettype wire

// ===== dv/spr_src.sv
// Purpose: Behavioural link source for the receiver.
// Assumes: 125 ns bit clock, one slot per rising edge, 32-slot subframes.
// Notes: The clock stands still low between calls.
`timescale 1ns/10ps
`default_nettype none
module spr_src (
    output logic link_clk,
    output logic link_data,
    output logic link_sync
);
    // Idle levels before the first subframe.
    initial begin
        link_clk = 1'h0;
        link_data = 1'h0;
        link_sync = 1'h0;
    end

    // One subframe; parity keeps slots 4 to 31 even, so only v makes one invalid.
    task automatic send(input logic [23:0] s, input logic rch, input logic blk,
                        input logic v, input logic cs);
        logic [31:0] w;
        w = {1'h0, cs, 1'h0, v, s, 1'h0, blk, rch, 1'h0};
        w[31] = ^w[30:4];
        for (int i = 0; i < 32; i++) begin
            link_data = w[i];
            link_sync = (i == 0);
            #62.5 link_clk = 1'h1;
            #62.5 link_clk = 1'h0;
        end
        // A released line must not keep showing the last bit.
        link_data = ~w[31];
        link_sync = 1'h0;
    endtask
endmodule
`default_nettype wire

// ===== dv/spdif_receiver_control_status_tb.sv
// Purpose: Self-checking bench of the receiver control and status logic.
// Assumes: Byte address is four times the register index.
// Notes: Lock counts, loss behaviour, word length, format decode, interrupts.
`timescale 1ns/10ps
`default_nettype none
module spdif_receiver_control_status_tb;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    wire logic link_clk, link_data, link_sync;
    spr_pkg::spr_audio_t audio;
    logic frame_clk_out, lock_out, irq;
    logic [19:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
    logic [23:0] l_s, r_s;
    logic [15:0] code;
    int failures = 0, compares = 0, cycles = 0, nsub = 0, need = 0, nstb = 0, tog;
    integer seed = 32'hB39025B1;
    localparam logic [3:0] LC = 4'h2; // Left: 16 bits of 20.
    localparam logic [3:0] RC = 4'hD; // Right: 21 bits of 24.

    spr_receiver #(.ADDR_W(20)) uut (.clk_sys, .sys_rst, .link_clk, .link_data, .link_sync,
        .audio, .frame_clk_out, .lock_out, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    spr_src src (.link_clk, .link_data, .link_sync);

    ////////////////////////////////////////////////////////////////
    // Clock, strobe count, and a ceiling above the roughly 97,000 cycles of the run.
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        nstb <= nstb + 32'(audio.strobe);
        if (cycles == 99000) begin
            failures++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Comparison and verdict.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Bus master: holds each channel until taken, waits for the answer.
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        wr_r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] idx);
        @(posedge clk_sys);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        rd(idx);
        check(what, rd_d, exp);
    endtask

    // Expectation helpers: masks keep the top bits of a trimmed word.
    function automatic logic [23:0] rnd24();
        int x;
        x = $random(seed);
        return x[23:0];
    endfunction
    function automatic logic [23:0] wmask(input int bits);
        return 24'hFFFFFF << (24 - bits);
    endfunction
    function automatic logic csb(input int i, input logic na, input logic [3:0] c);
        if (i == 1) return na;
        return (i >= 32 && i <= 35) ? c[i - 32] : 1'h0;
    endfunction

    // One subframe, then the lock flag against the run of valid subframes.
    task automatic sub(input logic [23:0] s, input logic rch, input logic blk, input logic v,
                       input logic cs);
        src.send(s, rch, blk, v, cs);
        nsub = v ? 0 : nsub + 1;
        if (need > 0) check("lock", 32'(lock_out), 32'(nsub >= need));
    endtask
    task automatic pair(input int i, input logic [23:0] l, input logic [23:0] r, input logic na);
        sub(l, 1'h0, i == 0, 1'h0, csb(i, na, LC));
        sub(r, 1'h1, 1'h0, 1'h0, csb(i, na, RC));
    endtask
    task automatic irqchk(input logic e);
        repeat (3) @(posedge clk_sys);
        check("irq", 32'(irq), 32'(e));
    endtask
    task automatic watch();
        logic p;
        tog = 0;
        p = frame_clk_out;
        repeat (1000) begin
            @(posedge clk_sys);
            if (frame_clk_out !== p) tog++;
            p = frame_clk_out;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'h0;
        wr(spr_pkg::IDX_DECODE, 32'h0000FFFF);
        check("ro write", 32'(wr_r), 32'(spr_pkg::RESP_OKAY));
        rchk("ctrl", spr_pkg::IDX_CTRL, 32'h0);
        rchk("decode", spr_pkg::IDX_DECODE, 32'h0);
        rchk("comp", spr_pkg::IDX_COMP, 32'h0);
        rd(16'hF6FF);
        check("unmapped", 32'(rd_r), 32'(spr_pkg::RESP_SLVERR));
        // Quick lock, loss behaviour 1; an invalid subframe restarts the run.
        wr(spr_pkg::IDX_CTRL, 32'hC);
        wr(spr_pkg::IDX_IRQ_ENABLE, 32'h7);
        need = 8;
        for (int k = 0; k < 16; k++) sub(rnd24(), k[0], 1'h0, k == 7, 1'h0);
        irqchk(1'h1);
        for (int c = 0; c < 3; c++) begin
            wr(spr_pkg::IDX_CTRL, 32'hC | 32'(c));
            l_s = rnd24();
            r_s = rnd24();
            tog = nstb;
            pair(40, l_s, r_s, 1'h0);
            check("left", 32'(audio.left), 32'(l_s & wmask(24 - 4 * c)));
            check("right", 32'(audio.right), 32'(r_s & wmask(24 - 4 * c)));
            check("strobe", 32'(nstb - tog), 32'h1);
        end
        wr(spr_pkg::IDX_IRQ_CLEAR, 32'h7);
        irqchk(1'h0);
        wr(spr_pkg::IDX_IRQ_ENABLE, 32'h1);
        repeat (300) @(posedge clk_sys);
        check("lost", 32'(lock_out), 32'h0);
        check("mute", 32'(audio.left), 32'h0);
        irqchk(1'h0);
        rchk("status", spr_pkg::IDX_IRQ_STATUS, 32'h2);
        watch();
        check("fclk stop", 32'(tog), 32'h0);
        wr(spr_pkg::IDX_IRQ_ENABLE, 32'h2);
        irqchk(1'h1);
        wr(spr_pkg::IDX_IRQ_CLEAR, 32'h2);
        irqchk(1'h0);
        // Normal lock, then a status block (gathered only while locked), then automatic length.
        wr(spr_pkg::IDX_CTRL, 32'h3);
        nsub = 0;
        need = 64;
        for (int i = -32; i < 36; i++) pair(i, rnd24(), rnd24(), 1'h0);
        rchk("decode", spr_pkg::IDX_DECODE, {22'h0, RC, LC, 2'h0});
        l_s = rnd24();
        r_s = rnd24();
        pair(36, l_s, r_s, 1'h0);
        check("auto l", 32'(audio.left), 32'(l_s & wmask(16)));
        check("auto r", 32'(audio.right), 32'(r_s & wmask(21)));
        // Compressed block, then a burst carrying the code.
        code = 16'(rnd24());
        code[4:0] = 5'h0C; // Mid-range case: a code of the second family.
        for (int i = 0; i < 36; i++) pair(i, rnd24(), rnd24(), 1'h1);
        pair(36, 24'hF87200, 24'h4E1F00, 1'h1);
        pair(37, {code, 8'h0}, rnd24(), 1'h1);
        rchk("decode", spr_pkg::IDX_DECODE, {22'h0, RC, LC,
             code[4:0] >= 5'h0B && code[4:0] <= 5'h0D, 1'h1});
        rchk("comp", spr_pkg::IDX_COMP, {16'h0, code});
        // Loss with behaviour 0 keeps the frame clock running.
        repeat (300) @(posedge clk_sys);
        watch();
        check("fclk run", 32'(tog > 0), 32'h1);
        test_done();
    end
endmodule
`default_nettype wire
